// ### hw/exu_core.sv
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Among exceptions pending together, the most urgent one is serviced first.
// - Reset, NMI and hard fault hold fixed priorities -3, -2, -1 above all.
// - A disabled memory, bus or usage fault is escalated to hard fault.
// - A fault blocked by equal or higher running priority escalates to hard fault.
// - Exception numbers: 4,5,6 faults, 11,12,14,15 system, 16 up external.
// - Configurable priority: lower value is more urgent, zero most urgent.
// - On equal priority the smaller exception number wins.
// - Three priority bits kept in bits seven to five; low five read zero.
// - Split select divides field; compare pre-emption, then sub, then number.
// - Entry saves PC, status word, r0-r3, r12 and link register to stack.
// - After the entry save the stack pointer is eight words lower.
// - Vector base resets to zero and is relocatable by software.
// - A late, more urgent exception takes the vector without saving again.
// - An arrival with a more urgent pre-emption field pre-empts the running handler.
// - On return, an outranking pending exception is entered without pop or push.
// - Otherwise return resumes the most recently stacked handler.
// - With nothing pending or stacked, return resumes the background program.
// - Exit restores eight registers and raises the stack pointer.
// - Exit reloads the active exception number from the restored status word.
// - Handler mode uses the main stack; thread mode may use either.
// - Execute-never fetches and fault-region accesses raise fault exceptions.
module exu_core
	import exu_pkg::*;
(
	// Clock and reset.
	input  wire logic          clk,
	input  wire logic          arst_n,
	// APB slave.
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output var  logic          pready,
	output var  logic [31:0]   prdata,
	output var  logic          pslverr,
	// Exception sources.
	input  wire logic          nmi_req,
	input  wire logic [2:0]    fault_req,
	input  wire logic          execute_never_fetch,
	input  wire logic          fault_region_access,
	input  wire logic          supervisor_call,
	input  wire logic          debug_monitor_req,
	input  wire logic          pendable_service_request,
	input  wire logic          system_tick_timer,
	input  wire logic [15:0]   irq,
	// Core handshake.
	input  wire logic          handler_start,
	input  wire logic          exc_return,
	input  wire logic          return_use_psp,
	input  wire logic          pop_status_valid,
	input  wire logic [8:0]    pop_status_word,
	input  wire logic          init_msp_valid,
	input  wire logic [31:0]   init_msp,
	input  wire logic          thread_use_psp,
	input  wire logic [31:0]   thread_psp,
	// Core commands and state.
	output var  exu_stack_type stk_ff,
	output var  exu_vec_type   vec_ff,
	output var  logic [4:0]    active_num_ff,
	output var  logic          handler_mode_ff,
	output var  logic          psp_sel_ff,
	output var  logic          software_reset_request_ff
);
	function automatic logic [21:0] rank(input logic [4:0] n, input logic [2:0] p,
		input logic [2:0] split);
		logic [7:0] pri8;
		logic [7:0] pmask;
		pri8 = {p, 5'h00};
		pmask = (8'hff << split) << 1;
		if (n == EXC_RESET)
			rank = {9'h000, 8'h00, n};
		else if (n == EXC_NMI)
			rank = {9'h001, 8'h00, n};
		else if (n == EXC_HARD)
			rank = {9'h002, 8'h00, n};
		else
			rank = {1'b1, pri8 & pmask, pri8 & ~pmask, n};
	endfunction : rank

	exu_state_type state_ff;
	exu_state_type nxt_state;
	logic [31:0]   pend_ff;
	logic [31:0]   active_ff;
	logic [2:0]    pri_ff [32];
	logic [2:0]    fault_en_ff;
	logic [2:0]    split_ff;
	logic [24:0]   vtab_ff;
	logic [4:0]    sel_ff;
	logic [2:0]    cnt_ff;
	logic [8:0]    psw_ff;
	logic [31:0]   msp_ff;
	logic [31:0]   psp_ff;
	logic          pready_ff;
	logic [31:0]   prdata_ff;
	logic          pslverr_ff;
	logic [21:0]   best_key;
	logic [4:0]    best_num;
	logic          any_pend;
	logic [8:0]    stacked_pre;
	logic [31:0]   set_vec;

	// Arbitration keys: pre-emption, then sub-priority, then number.
	always_comb
	begin
		logic [21:0] k;
		k = '1;
		best_key = '1;
		best_num = 5'h00;
		stacked_pre = THREAD_PRE;
		for (int i = 1; i < 32; i++)
		begin
			k = rank(5'(i), pri_ff[i], split_ff);
			if (pend_ff[i] && k < best_key)
			begin
				best_key = k;
				best_num = 5'(i);
			end
			if (active_ff[i] && 5'(i) != active_num_ff && k[21:13] < stacked_pre)
				stacked_pre = k[21:13];
		end
	end

	wire       apb_acc = psel && penable && pready_ff;
	wire       apb_wr = apb_acc && pwrite;
	wire       pri_hit = paddr[7:2] >= ADDR_PRI0[7:2] && paddr[7:2] <= ADDR_PRI7[7:2];
	wire [2:0] pri_word = 3'(paddr[7:2] - ADDR_PRI0[7:2]);
	wire       reg_hit = pri_hit || paddr[7:2] <= ADDR_STAT[7:2];
	assign any_pend = best_key != '1;
	wire [21:0] cur_key = rank(active_num_ff, pri_ff[active_num_ff], split_ff);
	wire [8:0] cur_pre = handler_mode_ff ? cur_key[21:13] : THREAD_PRE;
	wire       take = any_pend && best_key[21:13] < cur_pre;
	wire       late = any_pend && best_key < rank(sel_ff, pri_ff[sel_ff], split_ff);
	wire       chain = any_pend && best_key[21:13] < stacked_pre;
	wire [31:0] sp_cur = psp_sel_ff ? psp_ff : msp_ff;
	wire [2:0] fault_raw = {fault_req[2], fault_req[1] | fault_region_access,
		fault_req[0] | execute_never_fetch};

	// Fault escalation: disabled or blocked faults become hard faults.
	always_comb
	begin
		logic [4:0]  fn;
		logic [21:0] fk;
		fn = EXC_MEM;
		fk = '0;
		set_vec = 32'h0000_0000;
		for (int f = 0; f < 3; f++)
		begin
			fn = EXC_MEM + 5'(f);
			fk = rank(fn, pri_ff[fn], split_ff);
			if (fault_raw[f])
			begin
				if (!fault_en_ff[f] || fk[21:13] >= cur_pre)
					set_vec[EXC_HARD] = 1'b1;
				else
					set_vec[fn] = 1'b1;
			end
		end
		set_vec[EXC_NMI] = set_vec[EXC_NMI] | nmi_req;
		set_vec[EXC_SVC] = supervisor_call;
		set_vec[EXC_DBG] = debug_monitor_req;
		set_vec[EXC_PSVC] = pendable_service_request;
		set_vec[EXC_TICK] = system_tick_timer;
		set_vec[31:16] = irq;
	end

	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			EXU_RUN:
				if (exc_return && handler_mode_ff)
					nxt_state = chain ? EXU_VEC : EXU_POP;
				else if (take)
					nxt_state = EXU_PUSH;
			EXU_PUSH:
				if (cnt_ff == LAST_WORD)
					nxt_state = EXU_VEC;
			EXU_VEC:
				if (handler_start)
					nxt_state = EXU_RUN;
			EXU_POP:
				if (cnt_ff == LAST_WORD)
					nxt_state = EXU_RUN;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			state_ff <= EXU_VEC;
		else
			state_ff <= nxt_state;
	end

	// Pending and active tracking; a new request beats the clear on entry.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pend_ff <= 32'h0000_0000;
			active_ff <= 32'h0000_0000;
		end
		else
		begin
			pend_ff <= (pend_ff & ~((state_ff == EXU_VEC && handler_start) ?
				(32'h1 << sel_ff) : 32'h0)) | set_vec;
			if (state_ff == EXU_VEC && handler_start && sel_ff != EXC_RESET)
				active_ff <= active_ff | (32'h1 << sel_ff);
			else if (state_ff == EXU_RUN && exc_return && handler_mode_ff)
				active_ff <= active_ff & ~(32'h1 << active_num_ff);
		end
	end

	// Selected exception, frame counter and restored status.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sel_ff <= EXC_RESET;
			cnt_ff <= 3'h0;
			psw_ff <= 9'h000;
		end
		else
		begin
			cnt_ff <= (state_ff == EXU_PUSH || state_ff == EXU_POP) ? cnt_ff + 3'h1 : 3'h0;
			if (state_ff == EXU_RUN && (take || (exc_return && chain)))
				sel_ff <= best_num;
			else if ((state_ff == EXU_PUSH || state_ff == EXU_VEC) && late)
				sel_ff <= best_num;
			if (pop_status_valid)
				psw_ff <= pop_status_word;
		end
	end

	// Stack pointers and mode.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			msp_ff <= 32'h0000_0000;
			psp_ff <= 32'h0000_0000;
			psp_sel_ff <= 1'b0;
			handler_mode_ff <= 1'b0;
			active_num_ff <= 5'h00;
		end
		else
		begin
			if (init_msp_valid)
				msp_ff <= init_msp;
			else if (!psp_sel_ff && state_ff == EXU_PUSH && cnt_ff == LAST_WORD)
				msp_ff <= msp_ff - FRAME_BYTES;
			else if (!psp_sel_ff && state_ff == EXU_POP && cnt_ff == LAST_WORD)
				msp_ff <= msp_ff + FRAME_BYTES;
			if (thread_use_psp && !handler_mode_ff && state_ff == EXU_RUN)
				psp_ff <= thread_psp;
			else if (psp_sel_ff && state_ff == EXU_PUSH && cnt_ff == LAST_WORD)
				psp_ff <= psp_ff - FRAME_BYTES;
			else if (psp_sel_ff && state_ff == EXU_POP && cnt_ff == LAST_WORD)
				psp_ff <= psp_ff + FRAME_BYTES;
			if (state_ff == EXU_VEC && handler_start)
			begin
				// The reset handler is the background program, so it must not block later entries.
				handler_mode_ff <= sel_ff != EXC_RESET;
				active_num_ff <= (sel_ff == EXC_RESET) ? 5'h00 : sel_ff;
				psp_sel_ff <= 1'b0;
			end
			else if (state_ff == EXU_RUN && !handler_mode_ff)
				psp_sel_ff <= thread_use_psp;
			else if (state_ff == EXU_POP && cnt_ff == LAST_WORD)
			begin
				active_num_ff <= psw_ff[4:0];
				handler_mode_ff <= psw_ff[4:0] != 5'h00;
				psp_sel_ff <= psw_ff[4:0] == 5'h00 && return_use_psp;
			end
		end
	end

	// Stack and vector commands to the core.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stk_ff <= '0;
			vec_ff <= '0;
		end
		else
		begin
			stk_ff.push <= state_ff == EXU_PUSH;
			stk_ff.pop <= state_ff == EXU_POP;
			stk_ff.idx <= cnt_ff;
			stk_ff.addr <= (state_ff == EXU_POP) ? sp_cur + {27'h0, cnt_ff, 2'b00} :
				sp_cur - FRAME_BYTES + {27'h0, cnt_ff, 2'b00};
			vec_ff.req <= state_ff == EXU_VEC && !handler_start;
			vec_ff.addr <= {vtab_ff, 7'h00} + {25'h0, sel_ff, 2'b00};
		end
	end

	// APB register file with one wait state.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fault_en_ff <= 3'h0;
			split_ff <= 3'h0;
			vtab_ff <= VTAB_RST[31:VTAB_LSB];
			software_reset_request_ff <= 1'b0;
			pready_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
			for (int i = 0; i < 32; i++)
				pri_ff[i] <= 3'h0;
		end
		else
		begin
			pready_ff <= psel && penable && !pready_ff;
			pslverr_ff <= psel && penable && !pready_ff && !reg_hit;
			if (apb_wr && paddr[7:2] == ADDR_CTRL[7:2])
			begin
				fault_en_ff <= pwdata[CTRL_EN_LSB +: 3];
				split_ff <= pwdata[CTRL_SPLIT_LSB +: 3];
				software_reset_request_ff <= pwdata[CTRL_SWRST_BIT];
			end
			if (apb_wr && paddr[7:2] == ADDR_VTAB[7:2])
				vtab_ff <= pwdata[31:VTAB_LSB];
			for (int b = 0; b < 4; b++)
				if (apb_wr && pri_hit && CONFIG_MASK[{pri_word, 2'(b)}])
					pri_ff[{pri_word, 2'(b)}] <= pwdata[8*b+PRI_LSB +: 3];
			prdata_ff <= 32'h0000_0000;
			if (psel && !pwrite && !pready_ff)
			begin
				if (paddr[7:2] == ADDR_CTRL[7:2])
					prdata_ff <= {15'h0, software_reset_request_ff, 5'h0, split_ff,
						5'h0, fault_en_ff};
				else if (paddr[7:2] == ADDR_VTAB[7:2])
					prdata_ff <= {vtab_ff, 7'h00};
				else if (paddr[7:2] == ADDR_STAT[7:2])
					prdata_ff <= {11'h000, state_ff, handler_mode_ff, psp_sel_ff, any_pend,
						best_num, 6'h0, active_num_ff};
				else if (pri_hit)
					for (int b = 0; b < 4; b++)
						prdata_ff[8*b +: 8] <= {pri_ff[{pri_word, 2'(b)}], 5'h00};
			end
		end
	end

	assign pready = pready_ff;
	assign prdata = prdata_ff;
	assign pslverr = pslverr_ff;

	sequence s_push_frame;
		stk_ff.push [*8];
	endsequence
	sequence s_pop_frame;
		stk_ff.pop [*8];
	endsequence

	property p_push_eight;
		@(posedge clk) disable iff (!arst_n) $rose(stk_ff.push) |-> s_push_frame ##1 !stk_ff.push;
	endproperty
	a_push_eight: assert property (p_push_eight) else $error("entry frame not eight words");

	property p_sp_down;
		@(posedge clk) disable iff (!arst_n)
			$rose(stk_ff.push) && !init_msp_valid |-> ##7 sp_cur == $past(sp_cur, 7) - FRAME_BYTES;
	endproperty
	a_sp_down: assert property (p_sp_down) else $error("stack pointer not lowered by 32");

	property p_pop_eight;
		@(posedge clk) disable iff (!arst_n) $rose(stk_ff.pop) |-> s_pop_frame ##1 !stk_ff.pop;
	endproperty
	a_pop_eight: assert property (p_pop_eight) else $error("exit frame not eight words");

	property p_vec_addr;
		@(posedge clk) disable iff (!arst_n)
			vec_ff.req |-> vec_ff.addr == {$past(vtab_ff), 7'h00} + {25'h0, $past(sel_ff), 2'b00};
	endproperty
	a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");

	property p_no_repush;
		@(posedge clk) disable iff (!arst_n) vec_ff.req ##1 vec_ff.req |-> !stk_ff.push;
	endproperty
	a_no_repush: assert property (p_no_repush) else $error("stack saved again");

	property p_escalate;
		@(posedge clk) disable iff (!arst_n)
			fault_req[0] && !fault_en_ff[0] |=> pend_ff[EXC_HARD];
	endproperty
	a_escalate: assert property (p_escalate) else $error("disabled fault not escalated");

	property p_tail_chain;
		@(posedge clk) disable iff (!arst_n)
			state_ff == EXU_RUN && exc_return && handler_mode_ff && chain
				|=> state_ff == EXU_VEC ##1 !stk_ff.pop;
	endproperty
	a_tail_chain: assert property (p_tail_chain) else $error("tail chain popped");

	property p_thread_ret;
		@(posedge clk) disable iff (!arst_n)
			state_ff == EXU_POP && cnt_ff == LAST_WORD && psw_ff[4:0] == 5'h00
				|=> !handler_mode_ff && psp_sel_ff == $past(return_use_psp);
	endproperty
	a_thread_ret: assert property (p_thread_ret) else $error("thread return wrong");

	property p_nmi_first;
		@(posedge clk) disable iff (!arst_n)
			pend_ff[EXC_NMI] && !pend_ff[EXC_RESET] |-> best_num == EXC_NMI;
	endproperty
	a_nmi_first: assert property (p_nmi_first) else $error("NMI not most urgent");

	property p_pri_low_zero;
		@(posedge clk) disable iff (!arst_n)
			pready_ff && !pwrite && $past(pri_hit) |-> (prdata_ff & 32'h1f1f1f1f) == 32'h0;
	endproperty
	a_pri_low_zero: assert property (p_pri_low_zero) else $error("priority low bits set");
endmodule : exu_core
`default_nettype wire

// ### hw/exu_pkg.sv
package exu_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_VTAB = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_PRI0 = 8'h10;
	localparam logic [7:0] ADDR_PRI7 = 8'h2c;
	localparam int CTRL_EN_LSB = 0;
	localparam int CTRL_SPLIT_LSB = 8;
	localparam int CTRL_SWRST_BIT = 16;
	localparam int VTAB_LSB = 7;
	localparam int PRI_LSB = 5;
	localparam logic [31:0] VTAB_RST = 32'h0000_0000;
	localparam logic [4:0] EXC_RESET = 5'h01;
	localparam logic [4:0] EXC_NMI = 5'h02;
	localparam logic [4:0] EXC_HARD = 5'h03;
	localparam logic [4:0] EXC_MEM = 5'h04;
	localparam logic [4:0] EXC_BUS = 5'h05;
	localparam logic [4:0] EXC_USAGE = 5'h06;
	localparam logic [4:0] EXC_SVC = 5'h0b;
	localparam logic [4:0] EXC_DBG = 5'h0c;
	localparam logic [4:0] EXC_PSVC = 5'h0e;
	localparam logic [4:0] EXC_TICK = 5'h0f;
	localparam logic [4:0] EXC_EXT0 = 5'h10;
	localparam logic [31:0] CONFIG_MASK = 32'hffffd870;
	localparam logic [2:0] LAST_WORD = 3'h7;
	localparam logic [31:0] FRAME_BYTES = 32'h0000_0020;
	localparam logic [8:0] THREAD_PRE = 9'h1ff;
	typedef enum logic [1:0] {
		EXU_RUN = 2'b00,
		EXU_PUSH = 2'b01,
		EXU_VEC = 2'b11,
		EXU_POP = 2'b10
	} exu_state_type;
	typedef struct packed {
		logic        push;
		logic        pop;
		logic [2:0]  idx;
		logic [31:0] addr;
	} exu_stack_type;
	typedef struct packed {
		logic        req;
		logic [31:0] addr;
	} exu_vec_type;
endpackage : exu_pkg

// ### testbench/exu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module exu_core_model
	import exu_pkg::*;
(
	// Clock and reset.
	input  wire logic          clk,
	input  wire logic          arst_n,
	// Commands from the exception unit, and the handler start delay set by the bench.
	input  wire exu_stack_type stk_ff,
	input  wire exu_vec_type   vec_ff,
	input  wire logic [4:0]    active_num_ff,
	input  wire logic [3:0]    start_delay,
	// Answers of the core.
	output var  logic          handler_start,
	output var  logic          pop_status_valid,
	output var  logic [8:0]    pop_status_word
);
	logic [8:0] frame_q[$];
	logic [4:0] wait_cnt;
	// The status word only means something while valid; otherwise it is scrambled.
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			handler_start    <= 1'b0;
			pop_status_valid <= 1'b0;
			pop_status_word  <= 9'h000;
			wait_cnt         <= 5'h00;
		end
		else
		begin
			handler_start    <= 1'b0;
			pop_status_valid <= 1'b0;
			pop_status_word  <= ~pop_status_word;
			if (vec_ff.req !== 1'b1)
				wait_cnt <= 5'h00;
			else if (wait_cnt <= {1'b0, start_delay})
				wait_cnt <= wait_cnt + 5'h01;
			if (vec_ff.req === 1'b1 && wait_cnt == {1'b0, start_delay})
				handler_start <= 1'b1;
			if (stk_ff.push === 1'b1 && stk_ff.idx == 3'h1)
				frame_q.push_back({4'h0, active_num_ff});
			if (stk_ff.pop === 1'b1 && stk_ff.idx == 3'h0 && frame_q.size() > 0)
			begin
				pop_status_valid <= 1'b1;
				pop_status_word  <= frame_q.pop_back();
			end
		end
	end
endmodule : exu_core_model
`default_nettype wire

// ### testbench/exception_priority_and_entry_exit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module exception_priority_and_entry_exit_bench
	import exu_pkg::*;
;
	logic          clk = 1'b0;
	logic          arst_n = 1'b0;
	logic          psel = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite = 1'b0;
	logic [7:0]    paddr = 8'h00;
	logic [31:0]   pwdata = 32'h0000_0000;
	logic [26:0]   src = 27'h0;
	logic          msp_load = 1'b0;
	logic [3:0]    delay = 4'h0;
	logic          ret_psp = 1'b0;
	logic          pready;
	logic [31:0]   prdata;
	logic          pslverr;
	logic          handler_start;
	logic          pop_valid;
	logic [8:0]    pop_word;
	exu_stack_type stk_ff;
	exu_vec_type   vec_ff;
	logic [4:0]    active_num_ff;
	logic          handler_mode_ff;
	logic          psp_sel_ff;
	logic          swrst;
	int            err_count = 0;
	int            num_checks = 0;
	int            push_cnt = 0;
	int            pop_cnt = 0;
	logic [31:0]   sp = 32'h0000_0000;
	logic [31:0]   base = 32'h0000_0000;
	int            bits[7] = '{22, 23, 24, 25, 20, 21, 19};
	logic [4:0]    nums[7] = '{EXC_SVC, EXC_DBG, EXC_PSVC, EXC_TICK, EXC_MEM, EXC_BUS, EXC_USAGE};

	always #5 clk = ~clk;

	exu_core exu_core_i (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .nmi_req(src[16]), .fault_req(src[19:17]),
		.execute_never_fetch(src[20]), .fault_region_access(src[21]),
		.supervisor_call(src[22]), .debug_monitor_req(src[23]),
		.pendable_service_request(src[24]), .system_tick_timer(src[25]), .irq(src[15:0]),
		.handler_start(handler_start), .exc_return(src[26]), .return_use_psp(ret_psp),
		.pop_status_valid(pop_valid), .pop_status_word(pop_word), .init_msp_valid(msp_load),
		.init_msp(32'h2000_1000), .thread_use_psp(1'b0), .thread_psp(32'h0000_0000),
		.stk_ff(stk_ff), .vec_ff(vec_ff), .active_num_ff(active_num_ff),
		.handler_mode_ff(handler_mode_ff), .psp_sel_ff(psp_sel_ff),
		.software_reset_request_ff(swrst));

	exu_core_model exu_core_model_i (.clk(clk), .arst_n(arst_n), .stk_ff(stk_ff),
		.vec_ff(vec_ff), .active_num_ff(active_num_ff), .start_delay(delay),
		.handler_start(handler_start), .pop_status_valid(pop_valid),
		.pop_status_word(pop_word));

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		check("read data", q, exp);
		check("read error", {31'h0, e}, {31'h0, experr});
	endtask : rd

	task fire(input logic [26:0] m);
		@(posedge clk);
		src <= m;
		@(posedge clk);
		src <= 27'h0;
	endtask : fire

	// Push and pop addresses are followed against a main stack pointer kept here.
	always @(posedge clk)
	begin
		if (stk_ff.push === 1'b1)
		begin
			check("push index", {29'h0, stk_ff.idx}, 32'(push_cnt % 8));
			check("push address", stk_ff.addr, sp - 32'h20 + {27'h0, stk_ff.idx, 2'b00});
			push_cnt++;
			if (stk_ff.idx == 3'h7)
				sp = sp - 32'h20;
		end
		if (stk_ff.pop === 1'b1)
		begin
			check("pop address", stk_ff.addr, sp + {27'h0, stk_ff.idx, 2'b00});
			pop_cnt++;
			if (stk_ff.idx == 3'h7)
				sp = sp + 32'h20;
		end
	end

	task expect_vec(input logic [4:0] num, input int pushes);
		int n;
		n = 0;
		while (vec_ff.req !== 1'b1 && n < 100)
		begin
			@(posedge clk);
			n++;
		end
		check("vector address", vec_ff.addr, base + {25'h0, num, 2'b00});
		while (vec_ff.req === 1'b1 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		@(posedge clk);
		check("vector wait", 32'(n < 200), 32'h1);
		check("push count", 32'(push_cnt), 32'(pushes));
		push_cnt = 0;
		if (num != EXC_RESET)
		begin
			check("active number", {27'h0, active_num_ff}, {27'h0, num});
			check("handler mode", {30'h0, handler_mode_ff, psp_sel_ff}, 32'h2);
		end
		else
			check("reset mode", {31'h0, handler_mode_ff}, 32'h0);
	endtask : expect_vec

	task ret(input logic [4:0] num, input int pops);
		int n;
		n = 0;
		pop_cnt = 0;
		fire(27'h400_0000);
		if (pops == 0)
			expect_vec(num, 0);
		else
		begin
			while (pop_cnt < 8 && n < 100)
			begin
				@(posedge clk);
				n++;
			end
			repeat (2) @(posedge clk);
			check("return number", {27'h0, active_num_ff}, {27'h0, num});
			check("return mode", {31'h0, handler_mode_ff}, 32'(num != 5'h00));
		end
		check("pop count", 32'(pop_cnt), 32'(pops));
	endtask : ret

	task test_done;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done

	initial
	begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		expect_vec(EXC_RESET, 0);
		msp_load <= 1'b1;
		sp = 32'h2000_1000;
		@(posedge clk);
		msp_load <= 1'b0;
		rd(ADDR_VTAB, 32'h0000_0000, 1'b0);
		wr(ADDR_PRI0, 32'hffff_ffff);
		rd(ADDR_PRI0, 32'h0000_0000, 1'b0);
		wr(ADDR_PRI0 + 8'h0c, 32'hffff_ffff);
		rd(ADDR_PRI0 + 8'h0c, 32'he0e0_00e0, 1'b0);
		rd(8'h30, 32'h0000_0000, 1'b1);
		wr(ADDR_CTRL, 32'h0000_0007);
		base = 32'h2000_0000;
		wr(ADDR_VTAB, base);
		wr(ADDR_PRI0 + 8'h04, 32'h0020_2020);
		wr(ADDR_PRI0 + 8'h08, 32'ha000_0000);
		wr(ADDR_PRI0 + 8'h10, 32'h8020_2060);
		fire(27'h6);
		expect_vec(EXC_EXT0 + 5'h01, 8);
		rd(ADDR_STAT, 32'h0005_9011, 1'b0);
		ret(EXC_EXT0 + 5'h02, 0);
		ret(5'h00, 8);
		fire(27'h1_0009);
		expect_vec(EXC_NMI, 8);
		ret(EXC_EXT0, 0);
		ret(EXC_EXT0 + 5'h03, 0);
		ret(5'h00, 8);
		for (int i = 0; i < 7; i++)
		begin
			fire(27'h1 << bits[i]);
			expect_vec(nums[i], 8);
			ret(5'h00, 8);
		end
		wr(ADDR_CTRL, 32'h0000_0000);
		fire(27'h2_0000);
		expect_vec(EXC_HARD, 8);
		ret(5'h00, 8);
		wr(ADDR_CTRL, 32'h0000_0007);
		fire(27'h8);
		expect_vec(EXC_EXT0 + 5'h03, 8);
		fire(27'h4_0000);
		expect_vec(EXC_BUS, 8);
		fire(27'h4_0000);
		expect_vec(EXC_HARD, 8);
		ret(EXC_BUS, 8);
		ret(EXC_EXT0 + 5'h03, 8);
		ret(5'h00, 8);
		delay <= 4'h5;
		fire(27'h8);
		while (stk_ff.push !== 1'b1)
			@(posedge clk);
		fire(27'h2);
		expect_vec(EXC_EXT0 + 5'h01, 8);
		ret(EXC_EXT0 + 5'h03, 0);
		ret(5'h00, 8);
		wr(ADDR_CTRL, 32'h0000_0607);
		fire(27'h1);
		expect_vec(EXC_EXT0, 8);
		fire(27'h2);
		ret(EXC_EXT0 + 5'h01, 0);
		ret_psp <= 1'b1;
		ret(5'h00, 8);
		wr(ADDR_CTRL, 32'h0001_0607);
		rd(ADDR_CTRL, 32'h0001_0607, 1'b0);
		check("software reset", {31'h0, swrst}, 32'h1);
		test_done;
	end

	initial
	begin
		#300000;
		err_count++;
		test_done;
	end
endmodule : exception_priority_and_entry_exit_bench
`default_nettype wire
